// >>> pkg/cos_pkg.sv
// Constants for the clamp, offset and sliced-sync control bank.
// Assumes a 250 MHz mclk and an AXI4-Lite master with 8-bit byte addresses.
package cos_pkg;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] IDX_LEVEL = 6'h18;
    localparam logic [5:0] IDX_PLACE = 6'h19;
    localparam logic [5:0] IDX_DUR = 6'h1A;
    localparam logic [5:0] IDX_CTRL = 6'h1B;
    localparam logic [5:0] IDX_TEST = 6'h1C;
    localparam logic [5:0] IDX_SYNC = 6'h1D;
    localparam logic [5:0] IDX_PWR = 6'h1E;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_LEVEL = 8'h20;
    localparam logic [7:0] RST_PLACE = 8'h08;
    localparam logic [7:0] RST_DUR = 8'h20;
    localparam logic [7:0] RST_CTRL = 8'h5B;
    localparam logic [7:0] RST_TEST = 8'hFF;
    localparam logic [7:0] RST_SYNC = 8'h78;
    localparam logic [7:0] RST_PWR = 8'h30;
    // ==========================================================
    // Field positions
    localparam int B_CLSRC = 4;
    localparam int B_RED = 3;
    localparam int B_GRN = 2;
    localparam int B_BLU = 1;
    localparam int B_CPOV = 7;
    localparam int B_CPOL = 6;
    localparam int B_AOEN = 5;
    localparam int F_AOF_HI = 4;
    localparam int F_AOF_LO = 3;
    localparam int F_THR_HI = 7;
    localparam int F_THR_LO = 3;
    localparam int B_SPOL = 2;
    localparam int F_SSEL_HI = 1;
    localparam int F_SSEL_LO = 0;
    localparam int B_CHOV = 7;
    localparam int B_CHSEL = 6;
    localparam int B_BW = 5;
    localparam int B_PDSEL = 4;
    localparam int B_PD = 3;
    // ==========================================================
    // Codes and counts
    localparam logic [1:0] AOF_3CL = 2'h0;
    localparam logic [1:0] AOF_48CL = 2'h1;
    localparam logic [1:0] AOF_192CL = 2'h2;
    localparam logic [7:0] AO_N3 = 8'h03;
    localparam logic [7:0] AO_N48 = 8'h30;
    localparam logic [7:0] AO_N192 = 8'hC0;
    localparam logic [1:0] SS_GREEN = 2'h0;
    localparam logic [1:0] SS_HORIZ = 2'h1;
    localparam logic [1:0] SS_REGEN = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int PIN_W = 6;
    typedef enum logic [2:0] {SEL_NONE, SEL_LEVEL, SEL_PLACE, SEL_DUR,
        SEL_CTRL, SEL_TEST, SEL_SYNC, SEL_PWR} cos_sel_t;
endpackage : cos_pkg

// >>> pkg/cos_clamp_if.sv
// Clamp settings and generated pulse between the register bank and
// the clamp timer. Same mclk on both sides.
`timescale 1ns/10ps
`default_nettype none
interface cos_clamp_if;
    logic hs_trail;
    logic enable;
    logic [7:0] place;
    logic [7:0] dur;
    logic clamp_pulse;
    modport ctl (output hs_trail, output enable, output place, output dur,
        input clamp_pulse);
    modport gen (input hs_trail, input enable, input place, input dur,
        output clamp_pulse);
endinterface : cos_clamp_if
`default_nettype wire

// >>> rtl/cos_sync_in.sv
// Three-stage synchroniser for asynchronous pins.
// Assumes pins change at any time against mclk.
`timescale 1ns/10ps
`default_nettype none
module cos_sync_in
#(
    parameter int W = 6
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pins and settled levels
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } cos_sy_st_t;
    cos_sy_st_t st_r;
    cos_sy_st_t st_nxt;

    // ==========================================================
    // Next state: a bit only moves once stages two and three agree
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.val[i] = st_r.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.val;
endmodule : cos_sync_in
`default_nettype wire

// >>> rtl/cos_clamp_gen.sv
// Internal clamp timer: delay then pulse, restarted every line.
// Assumes hs_trail is a one-cycle strobe on mclk.
`timescale 1ns/10ps
`default_nettype none
module cos_clamp_gen
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Settings in, pulse out
    cos_clamp_if.gen cif
);
    typedef enum logic [1:0] {CG_IDLE, CG_PLACE, CG_HOLD} cos_cg_t;
    typedef struct packed {
        cos_cg_t state;
        logic [7:0] cnt;
        logic pulse;
    } cos_cg_st_t;
    cos_cg_st_t st_r;
    cos_cg_st_t st_nxt;

    // ==========================================================
    // Placement count, then duration; a new edge restarts both
    always_comb
    begin
        st_nxt = st_r;
        if (!cif.enable)
        begin
            st_nxt.state = CG_IDLE;
            st_nxt.pulse = 1'b0;
        end
        else if (cif.hs_trail)
        begin
            st_nxt.pulse = 1'b0;
            st_nxt.state = CG_PLACE;
            st_nxt.cnt = cif.place;
        end
        else
        begin
            case (st_r.state)
                CG_PLACE:
                begin
                    if (st_r.cnt == 8'h00)
                    begin
                        // Zero duration gives no pulse at all
                        st_nxt.state = (cif.dur == 8'h00) ? CG_IDLE : CG_HOLD;
                        st_nxt.pulse = (cif.dur != 8'h00);
                        st_nxt.cnt = cif.dur - 8'h01;
                    end
                    else
                    begin
                        st_nxt.cnt = st_r.cnt - 8'h01;
                    end
                end
                CG_HOLD:
                begin
                    if (st_r.cnt == 8'h00)
                    begin
                        st_nxt.state = CG_IDLE;
                        st_nxt.pulse = 1'b0;
                    end
                    else
                    begin
                        st_nxt.cnt = st_r.cnt - 8'h01;
                    end
                end
                default:
                begin
                    st_nxt.state = CG_IDLE;
                    st_nxt.pulse = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '{state: CG_IDLE, cnt: 8'h00, pulse: 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign cif.clamp_pulse = st_r.pulse;
endmodule : cos_clamp_gen
`default_nettype wire

// >>> rtl/cos_top.sv
// Clamp, offset, sliced-sync and input/power control bank with AXI4-Lite.
// Assumes one 250 MHz mclk; sync pins arrive asynchronously, the
// filtered and regenerated syncs and detector hints come on mclk.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module cos_top
    import cos_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Asynchronous sync and clamp pins
    input wire logic [1:0] horiz_sync_inputs,
    input wire logic [1:0] green_sync_inputs,
    input wire logic vsync_in,
    input wire logic ext_clamp_in,
    // Same-clock hints from the sync processor
    input wire logic regen_hsync,
    input wire logic filtered_hsync,
    input wire logic hsync_pol_pos,
    input wire logic auto_clamp_pol,
    input wire logic auto_chan_sel,
    input wire logic [1:0] sync_present,
    // Analog front-end controls
    output logic clamp_mid_red,
    output logic clamp_mid_green,
    output logic clamp_mid_blue,
    output logic clamp_active,
    output logic auto_offset_en,
    output logic offset_update,
    output logic [4:0] slicer_threshold,
    output logic sliced_sync_out_pin,
    output logic chan_sel,
    output logic bw_high,
    output logic pd_auto,
    output logic power_down
);
    typedef struct packed {
        // Register bank
        logic [7:0] level;
        logic [7:0] place;
        logic [7:0] dur;
        logic [7:0] ctrl;
        logic [7:0] test;
        logic [7:0] sync;
        logic [7:0] pwr;
        // AXI slave
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        // Front-end state
        logic [7:0] ao_cnt;
        logic ao_pulse;
        logic vs_prev;
        logic hs_prev;
        logic clamp_act;
        logic ss_out;
        logic chan;
        logic pd;
    } cos_st_t;
    cos_st_t st_r;
    cos_st_t st_nxt;

    logic [PIN_W-1:0] pins_sync;
    logic [1:0] hs_lvl;
    logic [1:0] grn_lvl;
    logic vs_lvl;
    logic ext_lvl;
    cos_clamp_if cif ();

    // ==========================================================
    // Address decode, shared by the write and read paths
    function automatic cos_sel_t map_addr(input logic [7:0] a);
        case (a[7:2])
            IDX_LEVEL: map_addr = SEL_LEVEL;
            IDX_PLACE: map_addr = SEL_PLACE;
            IDX_DUR: map_addr = SEL_DUR;
            IDX_CTRL: map_addr = SEL_CTRL;
            IDX_TEST: map_addr = SEL_TEST;
            IDX_SYNC: map_addr = SEL_SYNC;
            IDX_PWR: map_addr = SEL_PWR;
            default: map_addr = SEL_NONE;
        endcase
    endfunction : map_addr

    // ==========================================================
    // Pin synchronisers and internal clamp timer
    cos_sync_in #(.W(PIN_W)) u_sync
    (
        .mclk(mclk),
        .rst(rst),
        .pin({ext_clamp_in, vsync_in, green_sync_inputs, horiz_sync_inputs}),
        .level(pins_sync)
    );

    // Unpack the settled pin levels
    assign hs_lvl = pins_sync[1:0];
    assign grn_lvl = pins_sync[3:2];
    assign vs_lvl = pins_sync[4];
    assign ext_lvl = pins_sync[5];

    cos_clamp_gen u_clamp
    (
        .mclk(mclk),
        .rst(rst),
        .cif(cif.gen)
    );

    // ==========================================================
    // Front-end decode from the register bank
    logic hs_act;
    logic clamp_pol;
    logic clamp_now;
    logic chan_nxt;
    logic vs_rise;
    logic clamp_end;
    logic ss_mux;
    logic [7:0] ao_target;

    always_comb
    begin
        // Channel: override or sync on both hands it to the select bit
        if (st_r.pwr[B_CHOV] || (&sync_present))
        begin
            chan_nxt = st_r.pwr[B_CHSEL];
        end
        else
        begin
            chan_nxt = auto_chan_sel;
        end
        // Active level of the selected hsync
        hs_act = hsync_pol_pos ? hs_lvl[st_r.chan] : ~hs_lvl[st_r.chan];
        // Clamp polarity only matters for the external clamp pin
        clamp_pol = st_r.ctrl[B_CPOV] ? st_r.ctrl[B_CPOL] : auto_clamp_pol;
        if (st_r.level[B_CLSRC])
        begin
            clamp_now = clamp_pol ? ext_lvl : ~ext_lvl;
        end
        else
        begin
            clamp_now = cif.clamp_pulse;
        end
        clamp_end = st_r.clamp_act & ~clamp_now;
        vs_rise = vs_lvl & ~st_r.vs_prev;
        // Sliced sync source
        case (st_r.sync[F_SSEL_HI:F_SSEL_LO])
            SS_GREEN: ss_mux = grn_lvl[st_r.chan];
            SS_HORIZ: ss_mux = hs_lvl[st_r.chan];
            SS_REGEN: ss_mux = regen_hsync;
            default: ss_mux = filtered_hsync;
        endcase
        // Auto-offset interval; the vsync mode reuses the 3-count
        case (st_r.ctrl[F_AOF_HI:F_AOF_LO])
            AOF_48CL: ao_target = AO_N48;
            AOF_192CL: ao_target = AO_N192;
            default: ao_target = AO_N3;
        endcase
    end

    // Settings handed to the clamp timer
    assign cif.hs_trail = st_r.hs_prev & ~hs_act;
    assign cif.enable = ~st_r.level[B_CLSRC];
    assign cif.place = st_r.place;
    assign cif.dur = st_r.dur;

    // ==========================================================
    // Next state: bus slave, registers, front-end flops
    logic ao_evt;
    logic wr_fire;
    cos_sel_t wsel;
    cos_sel_t rsel;

    always_comb
    begin
        st_nxt = st_r;
        // Write channels are taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wstrb0 = s_axi_wstrb[0];
        end
        wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
        wsel = map_addr(st_r.awaddr);
        if (wr_fire)
        begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            // Only byte lane 0 carries register data
            if (st_r.wstrb0)
            begin
                case (wsel)
                    SEL_LEVEL: st_nxt.level = st_r.wdata;
                    SEL_PLACE: st_nxt.place = st_r.wdata;
                    SEL_DUR: st_nxt.dur = st_r.wdata;
                    SEL_CTRL: st_nxt.ctrl = st_r.wdata;
                    SEL_TEST: st_nxt.test = st_r.wdata;
                    SEL_SYNC: st_nxt.sync = st_r.wdata;
                    SEL_PWR: st_nxt.pwr = st_r.wdata;
                    default: st_nxt.level = st_r.level;
                endcase
            end
        end
        if (st_r.bvalid && s_axi_bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        // Read: one outstanding, data captured with the address
        rsel = map_addr(s_axi_araddr);
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            case (rsel)
                SEL_LEVEL: st_nxt.rdata = st_r.level;
                SEL_PLACE: st_nxt.rdata = st_r.place;
                SEL_DUR: st_nxt.rdata = st_r.dur;
                SEL_CTRL: st_nxt.rdata = st_r.ctrl;
                SEL_TEST: st_nxt.rdata = st_r.test;
                SEL_SYNC: st_nxt.rdata = st_r.sync;
                SEL_PWR: st_nxt.rdata = st_r.pwr;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        else if (st_r.rvalid && s_axi_rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        // Front-end flops
        st_nxt.chan = chan_nxt;
        st_nxt.hs_prev = hs_act;
        st_nxt.vs_prev = vs_lvl;
        st_nxt.clamp_act = clamp_now;
        st_nxt.ss_out = st_r.sync[B_SPOL] ? ss_mux : ~ss_mux;
        // Auto control also powers down when no sync is seen
        st_nxt.pd = st_r.pwr[B_PD] | (st_r.pwr[B_PDSEL] & ~(|sync_present));
        // Auto-offset counts clamps or vsyncs per the rate field
        if (&st_r.ctrl[F_AOF_HI:F_AOF_LO])
        begin
            ao_evt = vs_rise;
        end
        else
        begin
            ao_evt = clamp_end;
        end
        st_nxt.ao_pulse = 1'b0;
        if (!st_r.ctrl[B_AOEN])
        begin
            st_nxt.ao_cnt = 8'h00;
        end
        else if (ao_evt)
        begin
            if (st_r.ao_cnt + 8'h01 >= ao_target)
            begin
                st_nxt.ao_cnt = 8'h00;
                st_nxt.ao_pulse = 1'b1;
            end
            else
            begin
                st_nxt.ao_cnt = st_r.ao_cnt + 8'h01;
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.level <= RST_LEVEL;
            st_r.place <= RST_PLACE;
            st_r.dur <= RST_DUR;
            st_r.ctrl <= RST_CTRL;
            st_r.test <= RST_TEST;
            st_r.sync <= RST_SYNC;
            st_r.pwr <= RST_PWR;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Bus handshakes; new writes wait until the response is gone
    assign s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
    assign s_axi_wready = ~st_r.w_got & ~st_r.bvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = ~st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = {24'h000000, st_r.rdata};

    // ==========================================================
    // Front-end outputs from register bits and flops
    assign clamp_mid_red = st_r.level[B_RED];
    assign clamp_mid_green = st_r.level[B_GRN];
    assign clamp_mid_blue = st_r.level[B_BLU];
    assign clamp_active = st_r.clamp_act;
    assign auto_offset_en = st_r.ctrl[B_AOEN];
    assign offset_update = st_r.ao_pulse;
    assign slicer_threshold = st_r.sync[F_THR_HI:F_THR_LO];
    assign sliced_sync_out_pin = st_r.ss_out;
    assign chan_sel = st_r.chan;
    assign bw_high = st_r.pwr[B_BW];
    assign pd_auto = st_r.pwr[B_PDSEL];
    assign power_down = st_r.pd;
endmodule : cos_top
`default_nettype wire

// >>> dv/cos_monitor.sv
// Checker: bus handshakes, auto power-down, auto-offset pulses.
// Sees only cos_top ports.
`timescale 1ns/10ps
`default_nettype none
module cos_monitor
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Front-end controls
    input wire logic [1:0] sync_present,
    input wire logic pd_auto,
    input wire logic power_down,
    input wire logic auto_offset_en,
    input wire logic offset_update
);
    // ==========================================================
    // Properties, all on mclk and quiet during reset
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_w_refused; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_b_stands; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_r_stands; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_pd_auto; pd_auto && sync_present == 2'h0 |=> power_down; endproperty
    property p_off_pulse; offset_update |=> !offset_update [*2]; endproperty
    // Three quiet cycles so a pulse already in flight is not blamed
    property p_off_en; !auto_offset_en [*3] |-> !offset_update; endproperty
    a_w_refused: assert property (p_w_refused) else $error("write ready with response open");
    a_b_stands: assert property (p_b_stands) else $error("write response dropped early");
    a_r_refused: assert property (p_r_refused) else $error("read ready with data open");
    a_r_answer: assert property (p_r_answer) else $error("read data late");
    a_r_stands: assert property (p_r_stands) else $error("read data dropped early");
    a_pd_auto: assert property (p_pd_auto) else $error("no auto power-down");
    a_off_pulse: assert property (p_off_pulse) else $error("offset pulse too long");
    a_off_en: assert property (p_off_en) else $error("offset pulse while disabled");
    // Main scenarios reached
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_offset: cover property (offset_update);
endmodule : cos_monitor
`default_nettype wire

// >>> dv/clamp_offset_sog_input_control_test.sv
// Self-checking bench for cos_top: registers, outputs, clamp timing.
// Inputs change by NBA just after the rising mclk edge.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module clamp_offset_sog_input_control_test
    import cos_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] aw_a = 8'h00, ar_a = 8'h00, rdv;
    logic [31:0] wd = 32'h0, rdata;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, vs = 1'b0, ext = 1'b0;
    logic [1:0] hs = 2'h0, gs = 2'h0, sp = 2'h3, bresp, rresp, rs;
    logic regen = 1'b0, filt = 1'b0, cl_q = 1'b0;
    logic awr, wrr, bv, arr, rv, mr, mg, mb, clamp, aoen, offu, sso, csel, bw, pda, pd;
    logic [4:0] thr;
    int errors = 0, check_count = 0, offs = 0, rises = 0, i, j, d8, w;
    int ncl [3] = '{3, 48, 192};
    logic [7:0] rst_tab [7] = '{8'h20, 8'h08, 8'h20, 8'h5B, 8'hFF, 8'h78, 8'h30};
    // Rows: index, data written, {r,g,b,auto-offset,bw,pd auto,pd,threshold}
    logic [27:0] rows [12] = '{28'h180EECF, 28'h18088CF, 28'h18044CF, 28'h18022CF,
        28'h1E0020F, 28'h1E0822F, 28'h1E302CF, 28'h1B233CF, 28'h1B5B2CF,
        28'h1DA02D4, 28'h1D782CF, 28'h1CFF2CF};
    always #2 mclk = ~mclk;
    cos_top u_dut (.mclk(mclk), .rst(rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ar_a), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .horiz_sync_inputs(hs), .green_sync_inputs(gs), .vsync_in(vs), .ext_clamp_in(ext),
        .regen_hsync(regen), .filtered_hsync(filt), .hsync_pol_pos(1'b1),
        .auto_clamp_pol(1'b0), .auto_chan_sel(1'b0), .sync_present(sp),
        .clamp_mid_red(mr), .clamp_mid_green(mg), .clamp_mid_blue(mb), .clamp_active(clamp),
        .auto_offset_en(aoen), .offset_update(offu), .slicer_threshold(thr),
        .sliced_sync_out_pin(sso), .chan_sel(csel), .bw_high(bw), .pd_auto(pda),
        .power_down(pd));
    // Count offset pulses and clamp starts
    always @(posedge mclk)
    begin
        cl_q <= clamp;
        if (offu === 1'b1) offs <= offs + 1;
        if (clamp === 1'b1 && cl_q === 1'b0) rises <= rises + 1;
    end
    // ==========================================================
    // Bus and stimulus tasks; ready is read before the edge lands
    task automatic complete_run();
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge mclk);
        aw_a <= {idx, 2'b00};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge mclk);
            if (awr && awv) awv <= 1'b0;
            if (wrr && wv) wv <= 1'b0;
            if (bv) break;
        end
        bre <= 1'b0;
        `CHK(bresp, er)
        if (n == 200) begin errors++; complete_run(); end
    endtask : wr
    task automatic rd(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk);
        ar_a <= {idx, 2'b00};
        arv <= 1'b1;
        rre <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge mclk);
            if (arr && arv) arv <= 1'b0;
            if (rv) break;
        end
        rre <= 1'b0;
        d = rdata[7:0];
        r = rresp;
        if (n == 200) begin errors++; complete_run(); end
    endtask : rd
    task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
        rd(idx, rdv, rs);
        `CHK({rs, rdv}, {RESP_OKAY, e})
    endtask : rchk
    // One line on channel 0: 6 active cycles, then 60 watched cycles
    task automatic line(output int first, output int width);
        int k;
        first = -1;
        width = 0;
        @(posedge mclk);
        hs <= 2'h1;
        cyc(6);
        hs <= 2'h0;
        for (k = 0; k < 60; k++)
        begin
            @(posedge mclk);
            if (clamp === 1'b1 && first < 0) first = k;
            if (clamp === 1'b1) width++;
        end
    endtask : line
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        `CHK({mr, mg, mb, bw, pda, pd, thr, clamp}, 12'h19E)
        for (i = 0; i < 7; i++) rchk(IDX_LEVEL + 6'(i), rst_tab[i]);
        for (i = 0; i < 12; i++)
        begin
            wr(rows[i][25:20], rows[i][19:12], RESP_OKAY);
            rchk(rows[i][25:20], rows[i][19:12]);
            `CHK({mr, mg, mb, aoen, bw, pda, pd, thr}, rows[i][11:0])
        end
        wr(6'h1F, 8'h55, RESP_SLVERR);
        rd(6'h1F, rdv, rs);
        `CHK({rs, rdv}, {RESP_SLVERR, 8'h00})
        // Placement shift and duration, one clamp per line
        line(d8, w);
        `CHK(w, 32)
        wr(IDX_PLACE, 8'h14, RESP_OKAY);
        wr(IDX_DUR, 8'h05, RESP_OKAY);
        j = rises;
        line(i, w);
        `CHK(i - d8, 12)
        `CHK(w, 5)
        `CHK(rises - j, 1)
        wr(IDX_PLACE, 8'h02, RESP_OKAY);
        for (i = 0; i < 4; i++)
        begin
            wr(IDX_CTRL, 8'h03, RESP_OKAY);
            wr(IDX_CTRL, 8'h23 | 8'(i << 3), RESP_OKAY);
            j = offs;
            if (i < 3) repeat (ncl[i]) line(d8, w);
            else repeat (3) begin vs <= 1'b1; cyc(6); vs <= 1'b0; cyc(20); end
            `CHK(offs - j, 1)
        end
        wr(IDX_CTRL, 8'h5B, RESP_OKAY);
        // Each sliced-sync source, both polarities, others driven opposite
        for (i = 0; i < 8; i++)
        begin
            wr(IDX_SYNC, 8'h78 | 8'(i), RESP_OKAY);
            for (j = 0; j < 2; j++)
            begin
                {filt, regen, hs[0], gs[0]} <= (4'h1 << i[1:0]) ^ {4{j[0]}};
                cyc(8);
                `CHK(sso, i[2] ^ j[0])
            end
        end
        {filt, regen, hs[0], gs[0]} <= 4'h0;
        wr(IDX_PWR, 8'h70, RESP_OKAY);
        cyc(4);
        `CHK(csel, 1'b1)
        sp <= 2'h1;
        cyc(4);
        `CHK(csel, 1'b0)
        wr(IDX_PWR, 8'hF0, RESP_OKAY);
        cyc(4);
        `CHK(csel, 1'b1)
        sp <= 2'h0;
        cyc(4);
        `CHK(pd, 1'b1)
        wr(IDX_PWR, 8'h20, RESP_OKAY);
        cyc(4);
        `CHK(pd, 1'b0)
        sp <= 2'h3;
        wr(IDX_PWR, 8'h30, RESP_OKAY);
        // External clamp pin: chip polarity, then programmed both ways
        wr(IDX_LEVEL, 8'h10, RESP_OKAY);
        for (i = 0; i < 6; i++)
        begin
            if (i == 2) wr(IDX_CTRL, 8'hDB, RESP_OKAY);
            if (i == 4) wr(IDX_CTRL, 8'h9B, RESP_OKAY);
            ext <= i[0];
            cyc(8);
            `CHK(clamp, i[0] ^ (i[2:1] != 2'h1))
        end
        line(d8, w);
        `CHK(w, 0)
        complete_run();
    end
endmodule : clamp_offset_sog_input_control_test
bind cos_top cos_monitor u_mon (.mclk, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .sync_present, .pd_auto, .power_down, .auto_offset_en, .offset_update);
`default_nettype wire
